// file: flash_rd_defs.svh
// Purpose: constants for the serial flash read front end
// Assumes: included by the read front end module only
// Notes: opcodes, address widths and default dummy counts
`ifndef FLASH_RD_DEFS_SVH
`define FLASH_RD_DEFS_SVH
`define OP_NORMAL_READ 8'h03
`define OP_NORMAL_READ_WIDE 8'h13
`define OP_FAST_READ 8'h0b
`define OP_FAST_READ_WIDE 8'h0c
`define OP_QUAD_IO_READ 8'heb
`define OP_UID_READ 8'h4b
`define OP_PARAM_READ 8'h5a
`define OP_INFO_ROW_READ 8'h68
`define ADDR_BITS_NARROW 6'd24
`define ADDR_BITS_WIDE 6'd32
`define VALID_TOP_BIT 24
`define DUMMY_SINGLE_DEFAULT 5'd8
`define DUMMY_QUAD_DEFAULT 5'd6
`endif

// file: flash_rd_pkg.sv
// Purpose: shared types for the serial flash read front end
// Assumes: constants come from flash_rd_defs.svh
// Notes: holds only types
package flash_rd_pkg;
	typedef enum logic [2:0] {
		ST_IDLE,
		ST_OPCODE,
		ST_ADDR,
		ST_DUMMY,
		ST_DATA,
		ST_IGNORE
	} phase_t;
	typedef struct packed {
		logic [3:0] dout;
		logic [3:0] oe;
	} line_drive_t;
endpackage : flash_rd_pkg

// file: flash_rd_mem.sv
// Purpose: byte memory behind the read front end
// Assumes: one read per request, data registered
// Notes: contents start as the low address bits; a real array loads elsewhere
`timescale 1ns/1ns
module flash_rd_mem #(
	parameter int ADDR_W = 8
) (
	input wire logic core_clk_i, // core clock
	input wire logic [ADDR_W-1:0] rd_addr_i, // byte address
	input wire logic rd_en_i, // read request
	output logic [7:0] rd_data_o // registered byte
);
	logic [7:0] mem_q [0:(1<<ADDR_W)-1];
	// simple pattern so reads return a known, address-dependent value
	initial begin
		for (int i = 0; i < (1<<ADDR_W); i++) begin
			mem_q[i] = i[7:0];
		end
	end
	// registered read port
	always_ff @(posedge core_clk_i) begin
		if (rd_en_i) begin
			rd_data_o <= mem_q[rd_addr_i];
		end
	end
endmodule : flash_rd_mem

// file: flash_rd_front.sv
// Purpose: read command front end of a serial flash device
// Assumes: serial clock, select and pause are sampled by core_clk_i (20 MHz)
// Notes: serial clock must be well below core rate in simulation (400 ns period)
// Functional notes
// - 03h takes 3 or 4 bytes; 13h four
// - shift opcode then 24/32 address bits
// - decode bits 23..0 or 24..0 only
// - input ignored after the address phase
// - single-line data goes out MSB first
// - address increments after every byte sent
// - address wraps to zero past top
// - select high ends read, releases output
// - normal read ignored while write busy
// - 0Bh 3/4 bytes, 0Ch four bytes
// - single fast read: dummy cycles, default 8
// - sample on rise, drive on fall
// - quad mode: opcode 2 clocks, address 6/8
// - quad mode: dummy default 6, data four lines
// - quad sequence also for EBh, 4Bh, 5Ah
// - ID, parameter, info-row reads: 3-byte address
// - pause with clock low, state kept
// - paused: output released, input ignored
// - no pause in double-rate, quad-enable, reset-pin
// - fast read discarded while write busy
`timescale 1ns/1ns
`include "flash_rd_defs.svh"
module flash_rd_front #(
	parameter int MEM_ADDR_W = 25, // byte address width of the array
	parameter logic [4:0] DUMMY_SINGLE = `DUMMY_SINGLE_DEFAULT, // single-line fast read
	parameter logic [4:0] DUMMY_QUAD = `DUMMY_QUAD_DEFAULT // four-line fast read
) (
	input wire logic core_clk_i, // core clock
	input wire logic reset_n_i, // async reset, active low
	input wire logic sclk_i, // serial clock pin
	input wire logic select_n_i, // chip select pin, active low
	input wire logic pause_n_i, // pause pin, active low
	input wire logic [3:0] data_line_i, // data_line_3..data_line_0 in
	output logic [3:0] data_line_o, // data lines out
	output logic [3:0] data_line_oe_o, // data line output enables
	input wire logic extended_address_setting_i, // 1: four-byte address
	input wire logic write_in_progress_flag_i, // busy with write
	input wire logic four_line_command_mode_i, // four-line command mode
	input wire logic quad_enable_bit_i, // quad enable
	input wire logic double_rate_mode_i, // double-rate mode active
	input wire logic pause_pin_is_reset_i, // shared pin used as reset
	output logic busy_reject_o, // last command ignored as busy
	output logic reading_o // data phase active
);
	// elaboration checks: the counters below cannot serve other values
	if (MEM_ADDR_W < 1 || MEM_ADDR_W > `VALID_TOP_BIT + 1) begin : g_bad_addr_w
		$error("MEM_ADDR_W out of range");
	end
	// a zero dummy count would turn a fast read into a normal read
	if (DUMMY_SINGLE == 5'h00) begin : g_bad_dummy_single
		$error("DUMMY_SINGLE must be nonzero");
	end
	if (DUMMY_QUAD == 5'h00) begin : g_bad_dummy_quad
		$error("DUMMY_QUAD must be nonzero");
	end

	// a pin edge reaches the logic two to three core cycles late, so each serial half
	// period must span at least four core cycles; the serial rate is capped by that
	// two-flop synchronisers for every pin input
	logic [7:0] sync1_q;
	logic [7:0] sync2_q;
	always_ff @(posedge core_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			// idle levels: clock low, select and pause high, so no false edge follows reset
			sync1_q <= 8'h6f;
			sync2_q <= 8'h6f;
		end else begin
			sync1_q <= {sclk_i, select_n_i, pause_n_i, 1'b0, data_line_i};
			sync2_q <= sync1_q;
		end
	end
	logic sclk_s;
	logic sel_n_s;
	logic pause_n_s;
	logic [3:0] din_s;
	assign sclk_s = sync2_q[7];
	assign sel_n_s = sync2_q[6];
	assign pause_n_s = sync2_q[5];
	assign din_s = sync2_q[3:0];

	// edge detect on the synchronised serial clock
	logic sclk_prev_q;
	always_ff @(posedge core_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			sclk_prev_q <= 1'b0;
		end else begin
			sclk_prev_q <= sclk_s;
		end
	end

	// pause is latched only while the clock is low; disallowed modes force it off
	logic pause_allowed;
	logic paused_q;
	assign pause_allowed = !double_rate_mode_i && !quad_enable_bit_i && !pause_pin_is_reset_i;
	always_ff @(posedge core_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			paused_q <= 1'b0;
		end else if (sel_n_s || !pause_allowed) begin
			paused_q <= 1'b0;
		end else if (!sclk_s) begin
			paused_q <= !pause_n_s;
		end
	end

	logic rise;
	logic fall;
	// edges count only when selected and not paused, so state is kept during pause
	assign rise = sclk_s && !sclk_prev_q && !sel_n_s && !paused_q;
	assign fall = !sclk_s && sclk_prev_q && !sel_n_s && !paused_q;

	flash_rd_pkg::phase_t phase_q;
	logic [7:0] opcode_q;
	logic [5:0] bit_cnt_q; // bits or nibbles taken in the current phase
	logic [31:0] addr_sr_q;
	logic [5:0] addr_bits_q;
	logic [4:0] dummy_q;
	logic quad_q; // four-line command in progress
	logic [MEM_ADDR_W-1:0] addr_q;
	logic [7:0] shift_q;
	logic [2:0] out_cnt_q; // bits (or nibbles) left in the byte being sent
	logic load_d; // fetch of the next byte requested
	logic [7:0] mem_data;

	// opcode decode; address length and dummy count for the incoming opcode
	logic [7:0] op_next;
	logic op_known;
	logic op_fast;
	logic op_wide;
	always_comb begin
		// four-line mode takes a nibble per rise, single-line mode one bit on line 0
		op_next = four_line_command_mode_i ? {opcode_q[3:0], din_s} : {opcode_q[6:0], din_s[0]};
		op_known = 1'b0;
		op_fast = 1'b1;
		op_wide = extended_address_setting_i;
		case (op_next)
			`OP_NORMAL_READ: begin
				op_known = !four_line_command_mode_i;
				op_fast = 1'b0;
			end
			`OP_NORMAL_READ_WIDE: begin
				op_known = !four_line_command_mode_i;
				op_fast = 1'b0;
				op_wide = 1'b1;
			end
			`OP_FAST_READ: op_known = 1'b1;
			`OP_FAST_READ_WIDE: begin
				op_known = 1'b1;
				op_wide = 1'b1;
			end
			`OP_QUAD_IO_READ: op_known = four_line_command_mode_i;
			`OP_UID_READ, `OP_PARAM_READ, `OP_INFO_ROW_READ: begin
				op_known = four_line_command_mode_i;
				op_wide = 1'b0;
			end
			default: op_known = 1'b0;
		endcase
	end

	logic op_done;
	logic addr_done;
	// opcode ends on its eighth bit or second nibble, the address on its last bit or nibble
	assign op_done = four_line_command_mode_i ? (bit_cnt_q == 6'd1) : (bit_cnt_q == 6'd7);
	assign addr_done = quad_q ? ({bit_cnt_q, 2'b00} == addr_bits_q - 6'd4)
		: (bit_cnt_q == addr_bits_q - 6'd1);

	logic [31:0] addr_next;
	assign addr_next = quad_q ? {addr_sr_q[27:0], din_s} : {addr_sr_q[30:0], din_s[0]};

	// command sequencer; select high aborts anything in progress
	always_ff @(posedge core_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			phase_q <= flash_rd_pkg::ST_IDLE;
			opcode_q <= 8'h00;
			bit_cnt_q <= 6'h00;
			addr_sr_q <= 32'h0000_0000;
			addr_bits_q <= `ADDR_BITS_NARROW;
			dummy_q <= 5'h00;
			quad_q <= 1'b0;
			busy_reject_o <= 1'b0;
		end else if (sel_n_s) begin
			phase_q <= flash_rd_pkg::ST_OPCODE;
			opcode_q <= 8'h00;
			bit_cnt_q <= 6'h00;
		end else if (rise) begin
			case (phase_q)
				flash_rd_pkg::ST_OPCODE: begin
					opcode_q <= op_next;
					bit_cnt_q <= bit_cnt_q + 6'd1;
					if (op_done) begin
						bit_cnt_q <= 6'h00;
						quad_q <= four_line_command_mode_i;
						addr_bits_q <= op_wide ? `ADDR_BITS_WIDE : `ADDR_BITS_NARROW;
						dummy_q <= !op_fast ? 5'd0 : (four_line_command_mode_i ? DUMMY_QUAD : DUMMY_SINGLE);
						busy_reject_o <= op_known && write_in_progress_flag_i;
						if (!op_known || write_in_progress_flag_i) begin
							phase_q <= flash_rd_pkg::ST_IGNORE;
						end else begin
							phase_q <= flash_rd_pkg::ST_ADDR;
						end
					end
				end
				flash_rd_pkg::ST_ADDR: begin
					addr_sr_q <= addr_next;
					bit_cnt_q <= bit_cnt_q + 6'd1;
					if (addr_done) begin
						bit_cnt_q <= 6'h00;
						phase_q <= (dummy_q == 5'd0) ? flash_rd_pkg::ST_DATA : flash_rd_pkg::ST_DUMMY;
					end
				end
				flash_rd_pkg::ST_DUMMY: begin
					dummy_q <= dummy_q - 5'd1;
					if (dummy_q == 5'd1) begin
						phase_q <= flash_rd_pkg::ST_DATA;
					end
				end
				// data phase: the input line is dead until select goes high
				flash_rd_pkg::ST_DATA: phase_q <= flash_rd_pkg::ST_DATA;
				// refused command: stay silent until select goes high
				flash_rd_pkg::ST_IGNORE: phase_q <= flash_rd_pkg::ST_IGNORE;
				default: phase_q <= flash_rd_pkg::ST_IDLE;
			endcase
		end
	end

	// start address: only the valid low bits are decoded, upper bits dropped
	// bits above the array width are never looked at; with a 3-byte address a 25-bit array also has its top bit cleared
	logic [MEM_ADDR_W-1:0] start_addr;
	always_comb begin
		start_addr = addr_sr_q[MEM_ADDR_W-1:0];
		if (addr_bits_q == `ADDR_BITS_NARROW) begin
			start_addr[MEM_ADDR_W-1] = (MEM_ADDR_W > `VALID_TOP_BIT) ? 1'b0 : addr_sr_q[MEM_ADDR_W-1];
		end
	end

	// fetch the first byte when the data phase opens, then one per byte sent
	logic entering_data_q;
	always_ff @(posedge core_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			entering_data_q <= 1'b0;
		end else begin
			entering_data_q <= (phase_q != flash_rd_pkg::ST_DATA) && !sel_n_s && rise
				&& ((phase_q == flash_rd_pkg::ST_ADDR && addr_done && dummy_q == 5'd0)
				|| (phase_q == flash_rd_pkg::ST_DUMMY && dummy_q == 5'd1));
		end
	end

	flash_rd_mem #(
		.ADDR_W(MEM_ADDR_W)
	) u_mem (
		.core_clk_i(core_clk_i),
		.rd_addr_i(addr_q),
		.rd_en_i(1'b1),
		.rd_data_o(mem_data)
	);

	// address counter: load once the last address bit is in, then step after each byte;
	// loading during the address phase would drop that last bit. the counter is as wide
	// as the array, so passing the top wraps to zero with no extra logic
	always_ff @(posedge core_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			addr_q <= '0;
		end else if (entering_data_q) begin
			addr_q <= start_addr;
		end else if (load_d) begin
			addr_q <= addr_q + 1'b1;
		end
	end

	// set once the first bit of the data phase is out; lets a resume after a pause
	// re-enable the output without waiting for the next falling edge
	logic driving_q;
	always_ff @(posedge core_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			driving_q <= 1'b0;
		end else if (sel_n_s || phase_q != flash_rd_pkg::ST_DATA) begin
			driving_q <= 1'b0;
		end else if (fall) begin
			driving_q <= 1'b1;
		end
	end

	// output shifter; memory read takes a core cycle, far below half a serial period
	logic [2:0] last_cnt;
	assign last_cnt = quad_q ? 3'd1 : 3'd7;
	assign load_d = fall && phase_q == flash_rd_pkg::ST_DATA && out_cnt_q == 3'd0;
	flash_rd_pkg::line_drive_t drive;
	always_ff @(posedge core_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			shift_q <= 8'h00;
			out_cnt_q <= 3'd0;
			data_line_o <= 4'h0;
			data_line_oe_o <= 4'h0;
			reading_o <= 1'b0;
		end else if (sel_n_s || phase_q != flash_rd_pkg::ST_DATA) begin
			data_line_oe_o <= 4'h0;
			out_cnt_q <= 3'd0;
			reading_o <= 1'b0;
			if (entering_data_q) begin
				shift_q <= mem_data;
			end
		end else if (paused_q) begin
			// released while paused; bit count and shifter are kept for the resume
			data_line_oe_o <= 4'h0;
			reading_o <= 1'b0;
		end else begin
			reading_o <= 1'b1;
			if (entering_data_q) begin
				shift_q <= mem_data;
			end
			// each fall drives the next bit; a new byte starts from memory, already fetched
			if (fall) begin
				data_line_o <= drive.dout;
				data_line_oe_o <= drive.oe;
				if (out_cnt_q == 3'd0) begin
					out_cnt_q <= last_cnt;
					shift_q <= quad_q ? {mem_data[3:0], 4'h0} : {mem_data[6:0], 1'b0};
				end else begin
					out_cnt_q <= out_cnt_q - 3'd1;
					shift_q <= quad_q ? {shift_q[3:0], 4'h0} : {shift_q[6:0], 1'b0};
				end
			end else if (driving_q) begin
				// a resume re-enables the bit that stood on the line when the pause began
				data_line_oe_o <= drive.oe;
			end
		end
	end

	// first bit of a byte comes straight from memory so no fall is lost
	logic [7:0] src;
	always_comb begin
		src = (out_cnt_q == 3'd0) ? mem_data : shift_q;
		if (quad_q) begin
			drive.dout = src[7:4];
			drive.oe = 4'hf;
		end else begin
			drive.dout = {2'b00, src[7], 1'b0};
			drive.oe = 4'h2;
		end
	end
endmodule : flash_rd_front

// file: flash_rd_monitor.sv
// Purpose: pin-level checks on the read front end
// Assumes: bound into flash_rd_front, sees its ports only
// Notes: serial pins are raw here, so windows allow for the two-flop sync
`timescale 1ns/1ns
module flash_rd_monitor (
	input wire logic core_clk_i, // core clock
	input wire logic reset_n_i, // async reset, active low
	input wire logic sclk_i, // serial clock pin
	input wire logic select_n_i, // chip select, active low
	input wire logic pause_n_i, // pause pin, active low
	input wire logic [3:0] data_line_o, // data out
	input wire logic [3:0] data_line_oe_o, // output enables
	input wire logic write_in_progress_flag_i, // write busy
	input wire logic four_line_command_mode_i, // quad mode
	input wire logic quad_enable_bit_i, // quad enable
	input wire logic double_rate_mode_i, // double rate
	input wire logic pause_pin_is_reset_i, // pin used as reset
	input wire logic busy_reject_o, // refused as busy
	input wire logic reading_o // data phase
);
	default clocking @(posedge core_clk_i); endclocking
	default disable iff (!reset_n_i);
	// deselected long enough to pass the synchroniser
	sequence sel_idle_s;
		select_n_i [*5];
	endsequence
	// a pause that the configuration allows, held past the synchroniser
	sequence paused_s;
		(!pause_n_i && !select_n_i && !quad_enable_bit_i && !double_rate_mode_i
			&& !pause_pin_is_reset_i) [*5];
	endsequence
	a_select_release: assert property (sel_idle_s |-> data_line_oe_o == 4'h0)
		else $error("output driven while deselected");
	a_read_ends: assert property ($rose(select_n_i) |-> ##[1:6] !reading_o)
		else $error("data phase outlived select");
	a_pause_release: assert property (paused_s |-> data_line_oe_o == 4'h0)
		else $error("output driven while paused");
	a_single_line1: assert property (!four_line_command_mode_i && data_line_oe_o != 4'h0
		|-> data_line_oe_o == 4'h2)
		else $error("single mode drives a line other than line 1");
	a_quad_lines: assert property (four_line_command_mode_i && data_line_oe_o != 4'h0
		|-> data_line_oe_o == 4'hf)
		else $error("quad mode does not drive all four lines");
	a_drive_on_fall: assert property ($changed(data_line_o) && data_line_oe_o != 4'h0
		|-> !$past(sclk_i, 3))
		else $error("data changed away from a falling serial edge");
	a_busy_silent: assert property (busy_reject_o |-> data_line_oe_o == 4'h0)
		else $error("refused command drives the output");
	a_busy_cause: assert property ($rose(busy_reject_o) |-> write_in_progress_flag_i)
		else $error("refusal without write busy");
	a_busy_no_data: assert property (busy_reject_o |-> !reading_o)
		else $error("refused read entered the data phase");
endmodule : flash_rd_monitor
bind flash_rd_front flash_rd_monitor flash_rd_monitor_i (.core_clk_i(core_clk_i),
	.reset_n_i(reset_n_i), .sclk_i(sclk_i), .select_n_i(select_n_i), .pause_n_i(pause_n_i),
	.data_line_o(data_line_o), .data_line_oe_o(data_line_oe_o),
	.write_in_progress_flag_i(write_in_progress_flag_i),
	.four_line_command_mode_i(four_line_command_mode_i), .quad_enable_bit_i(quad_enable_bit_i),
	.double_rate_mode_i(double_rate_mode_i), .pause_pin_is_reset_i(pause_pin_is_reset_i),
	.busy_reject_o(busy_reject_o), .reading_o(reading_o));

// file: flash_host_model.sv
// Purpose: host serial controller model for the read front end
// Assumes: 400 ns serial period, far below the core rate
// Notes: undriven input lines carry a toggling filler, never a steady level
`timescale 1ns/1ns
module flash_host_model (
	input wire logic [3:0] data_line_o, // device data
	input wire logic [3:0] data_line_oe_o, // device enables
	output logic sclk_o, // serial clock, low when idle
	output logic select_n_o, // chip select, active low
	output logic pause_n_o, // pause, active low
	output logic [3:0] data_line_i // host drive
);
	logic [7:0] rx_q [0:3]; // bytes received
	logic [3:0] oe_seen; // enables seen in a command
	logic [3:0] pause_oe; // enables seen while paused
	logic [3:0] samp; // lines just before a fall
	logic tog; // filler phase
	int cnt; // clocks sent
	int pz_q; // clock index of the pause
	// idle: deselected, clock parked low
	initial begin
		sclk_o = 1'b0;
		select_n_o = 1'b1;
		pause_n_o = 1'b1;
		data_line_i = 4'h0;
		tog = 1'b0;
	end
	// pause and resume with the clock low; junk clocks in between must be ignored
	task automatic hold_gap();
		pause_n_o = 1'b0;
		repeat (2) begin
			#200 data_line_i = ~data_line_i;
			sclk_o = 1'b1;
			#200 pause_oe = pause_oe | data_line_oe_o;
			sclk_o = 1'b0;
		end
		#200 pause_n_o = 1'b1;
		#200;
	endtask : hold_gap
	// one clock at the top rate (half period of four core cycles): set with the clock low, sample before the fall
	task automatic tick(input logic q, input logic [3:0] v);
		if (cnt == pz_q) hold_gap();
		cnt++;
		tog = ~tog;
		data_line_i = q ? v : {{3{tog}}, v[0]};
		#200 sclk_o = 1'b1;
		// a released line reads as the inverse of its last value, so a lost enable shows
		#200 samp = data_line_o ^ ~data_line_oe_o;
		oe_seen = oe_seen | data_line_oe_o;
		sclk_o = 1'b0;
	endtask : tick
	// one read; pz is the clock index a pause goes before, -1 for none
	task automatic cmd(input logic q, input logic [7:0] op, input logic [31:0] a,
		input int ab, input int dm, input int nb, input int pz);
		int w;
		logic [7:0] b;
		w = q ? 4 : 1;
		cnt = 0;
		pz_q = pz;
		oe_seen = 4'h0;
		pause_oe = 4'h0;
		select_n_o = 1'b0;
		#200;
		for (int i = 8 - w; i >= 0; i -= w) tick(q, 4'(op >> i));
		for (int i = ab - w; i >= 0; i -= w) tick(q, 4'(a >> i));
		repeat (dm) tick(q, {4{tog}});
		for (int k = 0; k < nb; k++) begin
			for (int i = 0; i < 8; i += w) begin
				tick(q, {4{tog}});
				b = q ? {b[3:0], samp} : {b[6:0], samp[1]};
			end
			rx_q[k] = b;
		end
		select_n_o = 1'b1;
		#400;
	endtask : cmd
endmodule : flash_host_model

// file: serial_flash_read_front_end_bench.sv
// Purpose: self-checking bench for the read front end
// Assumes: array preloaded with byte equal to its low address bits
// Notes: 8-bit array so the wrap comes within a few bytes
`timescale 1ns/1ns
module serial_flash_read_front_end_bench;
	logic core_clk, reset_n, sclk, select_n, pause_n;
	logic [3:0] hdrv, din, dout, doe;
	logic ext, write_in_progress_flag, ql, qe, dr, prst, busy_reject, reading;
	logic [7:0] ops [4] = '{8'heb, 8'h4b, 8'h5a, 8'h68};
	int num_errors;
	int num_checks;
	// pin level: the device wins wherever it drives
	assign din = (doe & dout) | (~doe & hdrv);
	always #25 core_clk = ~core_clk;
	flash_rd_front #(.MEM_ADDR_W(8)) flash_rd_front_i (.core_clk_i(core_clk),
		.reset_n_i(reset_n), .sclk_i(sclk), .select_n_i(select_n), .pause_n_i(pause_n),
		.data_line_i(din), .data_line_o(dout), .data_line_oe_o(doe),
		.extended_address_setting_i(ext), .write_in_progress_flag_i(write_in_progress_flag),
		.four_line_command_mode_i(ql), .quad_enable_bit_i(qe), .double_rate_mode_i(dr),
		.pause_pin_is_reset_i(prst), .busy_reject_o(busy_reject), .reading_o(reading));
	flash_host_model flash_host_model_i (.data_line_o(dout), .data_line_oe_o(doe),
		.sclk_o(sclk), .select_n_o(select_n), .pause_n_o(pause_n), .data_line_i(hdrv));
	task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
		num_checks++;
		if (seen !== exp) begin
			num_errors++;
			$display("MISMATCH %s expected %h seen %h", name, exp, seen);
		end
	endtask : check
	task automatic report_and_stop();
		if (num_errors == 0 && num_checks > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask : report_and_stop
	// one read and its checks; bytes after a late pause are judged by the caller
	task automatic rd(input logic q, input logic [7:0] op, input logic [31:0] a,
		input int ab, input int dm, input int nb, input int pz);
		flash_host_model_i.cmd(q, op, a, ab, dm, nb, pz);
		check("reject", 8'(busy_reject), 8'(write_in_progress_flag));
		check("oe", 8'(flash_host_model_i.oe_seen), write_in_progress_flag ? 8'h0 : (q ? 8'hf : 8'h2));
		check("oe idle", 8'(doe), 8'h0);
		for (int k = 0; k < nb && !write_in_progress_flag && pz < 8 + ab; k++) begin
			check("data", flash_host_model_i.rx_q[k], a[7:0] + 8'(k));
		end
	endtask : rd
	// watchdog: a hang counts as a mismatch
	initial begin
		#3000000;
		num_errors++;
		report_and_stop();
	end
	initial begin
		core_clk = 1'b0;
		reset_n = 1'b0;
		{ext, write_in_progress_flag, ql, qe, dr, prst} = 6'h00;
		num_errors = 0;
		num_checks = 0;
		repeat (2) @(posedge core_clk);
		#1 reset_n = 1'b1;
		repeat (4) @(posedge core_clk);
		#1;
		rd(1'b0, 8'h03, 32'h1234fe, 24, 0, 3, -1);
		rd(1'b0, 8'h0b, 32'h30, 24, 8, 2, -1);
		rd(1'b0, 8'h13, 32'h20, 32, 0, 2, -1);
		rd(1'b0, 8'h03, 32'h55, 24, 0, 2, 12);
		check("paused oe", 8'(flash_host_model_i.pause_oe), 8'h00);
		rd(1'b0, 8'h03, 32'h55, 24, 0, 2, 34);
		check("held byte 0", flash_host_model_i.rx_q[0], 8'h55);
		check("held byte 1", flash_host_model_i.rx_q[1], 8'h56);
		check("held oe", 8'(flash_host_model_i.pause_oe), 8'h00);
		ext = 1'b1;
		rd(1'b0, 8'h03, 32'hfeffff10, 32, 0, 2, -1);
		rd(1'b0, 8'h0c, 32'h41, 32, 8, 1, -1);
		rd(1'b0, 8'h0b, 32'h42, 32, 8, 1, -1);
		// each setting that disables the pause: junk clocks then shift data on
		for (int i = 0; i < 3; i++) begin
			{qe, dr, prst} = 3'(1 << i);
			rd(1'b0, 8'h03, 32'ha0, 32, 0, 2, 40);
			check("no pause 0", flash_host_model_i.rx_q[0], 8'h82);
			check("no pause", flash_host_model_i.rx_q[1], 8'h86);
			check("no pause oe", 8'(flash_host_model_i.pause_oe), 8'h02);
		end
		{qe, dr, prst} = 3'h0;
		ql = 1'b1;
		rd(1'b1, 8'h0c, 32'h70, 32, 6, 2, -1);
		for (int i = 0; i < 4; i++) begin
			rd(1'b1, ops[i], 32'h80 + 32'(i), ops[i] == 8'heb ? 32 : 24, 6, 1, -1);
		end
		ext = 1'b0;
		rd(1'b1, 8'h0b, 32'h60, 24, 6, 2, -1);
		write_in_progress_flag = 1'b1;
		rd(1'b1, 8'h0b, 32'h10, 24, 6, 1, -1);
		ql = 1'b0;
		rd(1'b0, 8'h03, 32'h10, 24, 0, 1, -1);
		rd(1'b0, 8'h0b, 32'h10, 24, 8, 1, -1);
		write_in_progress_flag = 1'b0;
		rd(1'b0, 8'h03, 32'h11, 24, 0, 1, -1);
		flash_host_model_i.cmd(1'b0, 8'h4b, 32'h12, 24, 8, 1, -1);
		check("refused oe", 8'(flash_host_model_i.oe_seen), 8'h00);
		report_and_stop();
	end
endmodule : serial_flash_read_front_end_bench
